/* File: rtl/spi_cfg_params.svh */
// offsets, field positions, reset values and timing counts of the spi configuration register
// assumes inclusion by bare name
`ifndef SPI_CFG_PARAMS_SVH
`define SPI_CFG_PARAMS_SVH

// special function register address
`define SPI_CFG_ADDR 8'hA1

// field positions
`define CFG_BIT_BUSY 7
`define CFG_BIT_MASTER 6
`define CFG_BIT_PHASE 5
`define CFG_BIT_POLARITY 4
`define CFG_BIT_SELECTED 3
`define CFG_BIT_SEL_RAW 2
`define CFG_BIT_SHIFT_EMPTY 1
`define CFG_BIT_RX_EMPTY 0

// reset value of the whole register
`define SPI_CFG_RESET 8'h07

// pin synchroniser reset levels: select idles high
`define PINS_IDLE 4'h1

// select deglitch: level must be stable this many core cycles
`define SEL_FILT_CYCLES 3'h3

// master serial clock: core cycles per half period
`define MST_HALF_CYCLES 4'h4

// index of the last bit of a byte and of the last serial clock edge of a byte
`define BIT_LAST 3'h7
`define EDGE_LAST 4'hF

`endif

/* File: rtl/spi_cfg_pkg.sv */
// types shared by the spi configuration and status block
// assumes the _params header carries all numeric constants
package spi_cfg_pkg;

  // writable configuration fields
  typedef struct packed {
    logic master_select;
    logic sample_phase_select;
    logic idle_level_select;
  } spi_cfg_t;

  // serial pins seen by the device
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic select_input_n;
  } spi_pins_in_t;

  // serial pins driven by the device, enables active low
  typedef struct packed {
    logic sck;
    logic sck_oe_n;
    logic mosi;
    logic mosi_oe_n;
    logic miso;
    logic miso_oe_n;
  } spi_pins_out_t;

endpackage

/* File: rtl/link_sync.sv */
// two-flop synchroniser for the serial pins
// assumes pins are asynchronous to i_core_clk
`timescale 1ns/100ps
`include "spi_cfg_params.svh"

module link_sync
  import spi_cfg_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // pins
  input wire spi_pins_in_t i_async,
  output spi_pins_in_t o_sync
);

  localparam logic [3:0] IDLE = `PINS_IDLE;
  logic [3:0] in_bits;
  logic [3:0] meta_r;
  logic [3:0] sync_r;

  assign in_bits = i_async;
  assign o_sync = sync_r;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_bit
      always_ff @(posedge i_core_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          meta_r[g] <= IDLE[g];
          sync_r[g] <= IDLE[g];
        end
        else
        begin
          meta_r[g] <= in_bits[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

endmodule

/* File: rtl/select_deglitch.sv */
// glitch filter for the synchronised select level
// assumes its input is already on i_core_clk
`timescale 1ns/100ps
`include "spi_cfg_params.svh"

module select_deglitch
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // level in and filtered level out, idle high
  input wire logic i_level,
  output logic o_level
);

  logic [2:0] cnt_r;

  // a new level is accepted only after it held for the whole count
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt_r <= 3'h0;
      o_level <= 1'b1;
    end
    else if (i_level == o_level)
    begin
      cnt_r <= 3'h0;
    end
    else if (cnt_r == `SEL_FILT_CYCLES - 3'h1)
    begin
      cnt_r <= 3'h0;
      o_level <= i_level;
    end
    else
    begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

endmodule

/* File: rtl/spi_config_status_register.sv */
// spi configuration and status register with the shift engine it reports on
// assumes neighbouring control/data registers supply enable, tx writes and rx reads
`timescale 1ns/100ps
`include "spi_cfg_params.svh"

// Functional notes
// [R01] bit 7 busy while a transfer runs
// [R02] bit 6 picks master or slave
// [R03] bit 5 picks first or second edge
// [R04] bit 4 sets serial clock idle level
// [R05] bit 3 selected, from filtered select pin
// [R06] bit 2 raw select level at read
// [R07] slave: shifter empty once nothing pending
// [R08] shifter empty drops on load/edge, master reads 1
// [R09] slave: rx empty after buffer read
// [R10] rx empty 0 with unread byte, master 1
// [R11] software disables unit before phase/polarity change
// [R12] busy clears after final bit completes
module spi_config_status_register
  import spi_cfg_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // special function register access
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // neighbouring control and data registers
  input wire logic i_unit_enable,
  input wire logic i_tx_write,
  input wire logic [7:0] i_tx_data,
  input wire logic i_rx_read,
  output logic o_tx_buf_empty,
  output logic [7:0] o_rx_data,
  output logic o_xfer_done,
  // serial pins
  input wire spi_pins_in_t i_pins,
  output spi_pins_out_t o_pins
);

  localparam logic [7:0] RESET_VAL = `SPI_CFG_RESET;

  spi_pins_in_t pins_s;
  logic sel_filt_n;
  spi_cfg_t cfg_r;
  logic sfr_hit;
  logic slave_mode;
  logic slave_active;
  logic din;
  logic sck_d_r;
  logic sel_d_r;
  logic sel_fall;
  logic mst_run_r;
  logic [3:0] div_cnt_r;
  logic [3:0] edge_cnt_r;
  logic mst_edge;
  logic slv_edge;
  logic any_edge;
  logic lead;
  logic sample_p;
  logic shift_p;
  logic byte_done;
  logic load_go;
  logic [7:0] sh_r;
  logic [7:0] sh_in;
  logic [2:0] bit_cnt_r;
  logic out_r;
  logic sck_r;
  logic busy_r;
  logic sh_empty_r;
  logic tx_full_r;
  logic tx_full_nxt;
  logic [7:0] tx_buf_r;
  logic rx_full_r;
  logic shift_empty_flag;
  logic rx_empty_flag;

  link_sync u_link_sync
  (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_async(i_pins),
    .o_sync(pins_s)
  );

  select_deglitch u_select_deglitch
  (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_level(pins_s.select_input_n),
    .o_level(sel_filt_n)
  );

  assign sfr_hit = (i_sfr_addr == `SPI_CFG_ADDR);
  // [R02] mode select
  assign slave_mode = !cfg_r.master_select;
  assign slave_active = i_unit_enable && slave_mode && !pins_s.select_input_n;
  assign din = cfg_r.master_select ? pins_s.miso : pins_s.mosi;
  assign sel_fall = sel_d_r && !pins_s.select_input_n;

  // edge sources: own divider as master, sampled pin as slave
  assign mst_edge = mst_run_r && (div_cnt_r == `MST_HALF_CYCLES - 4'h1);
  assign slv_edge = slave_active && (pins_s.sck != sck_d_r);
  assign any_edge = cfg_r.master_select ? mst_edge : slv_edge;
  // leading edge moves away from the idle level
  assign lead = cfg_r.master_select ? !edge_cnt_r[0] : (pins_s.sck != cfg_r.idle_level_select);
  // [R03] sample on first edge when phase is 0, else second
  assign sample_p = any_edge && (lead != cfg_r.sample_phase_select);
  assign shift_p = any_edge && (lead == cfg_r.sample_phase_select);
  assign byte_done = sample_p && (bit_cnt_r == `BIT_LAST);
  assign sh_in = {sh_r[6:0], din};

  // master loads only when idle; slave when shifter empty or at byte end
  assign load_go = i_unit_enable && tx_full_r &&
                   (cfg_r.master_select ? (!mst_run_r && !busy_r) : (sh_empty_r || byte_done));
  assign tx_full_nxt = (i_tx_write && !tx_full_r) || (tx_full_r && !load_go);

  // [R08] constant 1 in master mode
  assign shift_empty_flag = cfg_r.master_select ? 1'b1 : sh_empty_r;
  // [R10] constant 1 in master mode
  assign rx_empty_flag = cfg_r.master_select ? 1'b1 : !rx_full_r;

  // writable configuration bits
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cfg_r <= {RESET_VAL[`CFG_BIT_MASTER], RESET_VAL[`CFG_BIT_PHASE],
                RESET_VAL[`CFG_BIT_POLARITY]};
    end
    else if (i_sfr_wr && sfr_hit)
    begin
      // no guard here: changing phase/polarity while enabled is the caller's hazard
      cfg_r <= {i_sfr_wdata[`CFG_BIT_MASTER], i_sfr_wdata[`CFG_BIT_PHASE],
                i_sfr_wdata[`CFG_BIT_POLARITY]};
    end
  end

  // register read
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_sfr_rdata <= 8'h00;
    end
    else if (i_sfr_rd && sfr_hit)
    begin
      // [R01] busy bit
      o_sfr_rdata[`CFG_BIT_BUSY] <= busy_r;
      o_sfr_rdata[`CFG_BIT_MASTER] <= cfg_r.master_select;
      o_sfr_rdata[`CFG_BIT_PHASE] <= cfg_r.sample_phase_select;
      o_sfr_rdata[`CFG_BIT_POLARITY] <= cfg_r.idle_level_select;
      // [R05] filtered select, inverted
      o_sfr_rdata[`CFG_BIT_SELECTED] <= !sel_filt_n;
      // [R06] raw select level
      o_sfr_rdata[`CFG_BIT_SEL_RAW] <= pins_s.select_input_n;
      o_sfr_rdata[`CFG_BIT_SHIFT_EMPTY] <= shift_empty_flag;
      o_sfr_rdata[`CFG_BIT_RX_EMPTY] <= rx_empty_flag;
    end
    else
    begin
      o_sfr_rdata <= 8'h00;
    end
  end

  // previous pin levels for edge finding
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sck_d_r <= 1'b0;
      sel_d_r <= 1'b1;
    end
    else
    begin
      sck_d_r <= pins_s.sck;
      sel_d_r <= pins_s.select_input_n;
    end
  end

  // master serial clock generator, 16 edges per byte
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mst_run_r <= 1'b0;
      div_cnt_r <= 4'h0;
      edge_cnt_r <= 4'h0;
    end
    else if (!i_unit_enable || !cfg_r.master_select)
    begin
      mst_run_r <= 1'b0;
      div_cnt_r <= 4'h0;
      edge_cnt_r <= 4'h0;
    end
    else if (load_go)
    begin
      mst_run_r <= 1'b1;
      div_cnt_r <= 4'h0;
      edge_cnt_r <= 4'h0;
    end
    else if (mst_edge)
    begin
      div_cnt_r <= 4'h0;
      edge_cnt_r <= edge_cnt_r + 4'h1;
      if (edge_cnt_r == `EDGE_LAST)
      begin
        mst_run_r <= 1'b0;
      end
    end
    else if (mst_run_r)
    begin
      div_cnt_r <= div_cnt_r + 4'h1;
    end
  end

  // [R04] serial clock rests at the idle level
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sck_r <= RESET_VAL[`CFG_BIT_POLARITY];
    end
    else if (!mst_run_r)
    begin
      sck_r <= cfg_r.idle_level_select;
    end
    else if (mst_edge)
    begin
      sck_r <= !sck_r;
    end
  end

  // shift register, bit counter and serial output bit
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sh_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      out_r <= 1'b0;
    end
    else
    begin
      if (load_go)
      begin
        sh_r <= tx_buf_r;
        out_r <= tx_buf_r[7];
      end
      else if (sample_p)
      begin
        sh_r <= sh_in;
      end
      else if (shift_p)
      begin
        out_r <= sh_r[7];
      end
      // three-wire users can only realign the count by disabling
      if (!i_unit_enable || sel_fall || byte_done)
      begin
        bit_cnt_r <= 3'h0;
      end
      else if (sample_p)
      begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
    end
  end

  // transfer busy
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      busy_r <= 1'b0;
    end
    else if (!i_unit_enable)
    begin
      busy_r <= 1'b0;
    end
    else if (cfg_r.master_select)
    begin
      // [R12] master busy ends with the last clock edge
      busy_r <= load_go || (mst_run_r && !(mst_edge && edge_cnt_r == `EDGE_LAST));
    end
    else if (byte_done || pins_s.select_input_n)
    begin
      // [R12] slave busy ends with the eighth sampled bit, or while select is high
      busy_r <= 1'b0;
    end
    else if (slv_edge && lead)
    begin
      // [R01] slave transfer starts on a leading edge
      busy_r <= 1'b1;
    end
  end

  // slave shift register empty flag
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sh_empty_r <= RESET_VAL[`CFG_BIT_SHIFT_EMPTY];
    end
    else if (!i_unit_enable || cfg_r.master_select)
    begin
      sh_empty_r <= 1'b1;
    end
    else if (load_go)
    begin
      // [R08] cleared on load from transmit buffer
      sh_empty_r <= 1'b0;
    end
    else if (byte_done)
    begin
      // [R07] set once the byte is through, nothing pending
      sh_empty_r <= 1'b1;
    end
    else if (slv_edge && (lead || busy_r))
    begin
      // [R08] cleared by a clock transition
      sh_empty_r <= 1'b0;
    end
  end

  // transmit holding buffer; writes while full are dropped
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tx_full_r <= 1'b0;
      tx_buf_r <= 8'h00;
      o_tx_buf_empty <= 1'b1;
    end
    else
    begin
      tx_full_r <= tx_full_nxt;
      o_tx_buf_empty <= !tx_full_nxt;
      if (i_tx_write && !tx_full_r)
      begin
        tx_buf_r <= i_tx_data;
      end
    end
  end

  // receive holding buffer; an overrun keeps the older byte
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rx_full_r <= 1'b0;
      o_rx_data <= 8'h00;
      o_xfer_done <= 1'b0;
    end
    else
    begin
      o_xfer_done <= byte_done;
      if (byte_done && !rx_full_r)
      begin
        // [R10] unread byte present; set wins over a same-cycle read
        rx_full_r <= 1'b1;
        o_rx_data <= sh_in;
      end
      else if (byte_done)
      begin
        rx_full_r <= 1'b1;
      end
      else if (i_rx_read)
      begin
        // [R09] empty after the buffer is read
        rx_full_r <= 1'b0;
      end
    end
  end

  // pin drivers, one cycle behind the engine
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_pins <= '{sck: 1'b0, sck_oe_n: 1'b1, mosi: 1'b0, mosi_oe_n: 1'b1,
                  miso: 1'b0, miso_oe_n: 1'b1};
    end
    else
    begin
      // [R02] master drives clock and mosi, slave drives miso when selected
      o_pins.sck <= sck_r;
      o_pins.sck_oe_n <= !(i_unit_enable && cfg_r.master_select);
      o_pins.mosi <= out_r;
      o_pins.mosi_oe_n <= !(i_unit_enable && cfg_r.master_select);
      o_pins.miso <= out_r;
      o_pins.miso_oe_n <= !slave_active;
    end
  end

endmodule

/* File: verif/spi_cfg_chk.sv */
// port checker for the spi configuration and status register
// assumes bind onto spi_config_status_register, 4-cycle master half period
`timescale 1ns/100ps
module spi_cfg_chk
  import spi_cfg_pkg::*;
(
  // clock, reset and register bus
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  // buffers and pins
  input wire logic i_rx_read,
  input wire logic o_tx_buf_empty,
  input wire logic o_xfer_done,
  input wire spi_pins_in_t i_pins,
  input wire spi_pins_out_t o_pins
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  logic [2:0] cfg_r;
  logic rxf_r;
  wire rd_hit = i_sfr_rd && i_sfr_addr == 8'hA1;
  wire sel_n = i_pins.select_input_n;
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      cfg_r <= 3'h0;
    else if (i_sfr_wr && i_sfr_addr == 8'hA1)
      cfg_r <= i_sfr_wdata[6:4];
  end
  // slave rx occupancy; a new byte wins over a same-cycle read
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rxf_r <= 1'b0;
    else if (o_xfer_done && !cfg_r[2])
      rxf_r <= 1'b1;
    else if (i_rx_read)
      rxf_r <= 1'b0;
  end
  AST_CFG_BACK: assert property (
    rd_hit && !i_sfr_wr |=> o_sfr_rdata[6:4] == cfg_r)
    else $error("config bits read back wrong");
  AST_MST_FLAGS: assert property (
    rd_hit && cfg_r[2] |=> o_sfr_rdata[1:0] == 2'h3)
    else $error("master empty flags not set");
  AST_SEL_RAW: assert property (
    $stable(sel_n)[*4] ##0 rd_hit |=> o_sfr_rdata[2] == $past(sel_n))
    else $error("raw select bit wrong");
  AST_SELECTED: assert property (
    $stable(sel_n)[*8] ##0 rd_hit |=> o_sfr_rdata[3] == !$past(sel_n))
    else $error("selected flag wrong");
  AST_RX_FLAG: assert property (
    rd_hit && !cfg_r[2] && !o_xfer_done && !$past(o_xfer_done) && !i_rx_read
    && !$past(i_rx_read) |=> o_sfr_rdata[0] == !rxf_r)
    else $error("rx empty flag wrong");
  AST_IDLE_LEVEL: assert property (
    ($stable(o_pins.sck) && $stable(cfg_r) && !o_pins.sck_oe_n)[*8] ##0 cfg_r[2]
    |-> o_pins.sck == cfg_r[0])
    else $error("serial clock idle level wrong");
  AST_BUSY_MID: assert property (
    (rd_hit && cfg_r[2] && $changed(o_pins.sck)) ##4 $changed(o_pins.sck)
    |-> $past(o_sfr_rdata[7], 3))
    else $error("busy low mid transfer");
  AST_BUSY_IDLE: assert property (
    ($stable(o_pins.sck) && $stable(o_tx_buf_empty))[*8] ##0
    (rd_hit && cfg_r[2] && o_tx_buf_empty) |=> !o_sfr_rdata[7])
    else $error("busy high while idle");
  cover property (o_xfer_done && cfg_r[2]);
  cover property (o_xfer_done && !cfg_r[2]);
  cover property (rd_hit && rxf_r);
endmodule

bind spi_config_status_register spi_cfg_chk u_chk (.*);

/* File: verif/spi_peer_model.sv */
// external spi device: master when the block is slave, slave otherwise
// assumes the bench sets phase and polarity before each transfer
`timescale 1ns/100ps
module spi_peer_model
  import spi_cfg_pkg::*;
(
  // block pins seen and pins driven back
  input wire spi_pins_out_t i_dut,
  output spi_pins_in_t o_line
);
  logic cpha = 1'b0;
  logic cpol = 1'b0;
  logic [7:0] rx_sr = 8'h00;
  initial o_line = 4'h1;
  // slave side samples on the chosen edge
  always @(i_dut.sck)
  begin
    if (!i_dut.sck_oe_n)
    begin
      if (i_dut.sck == !(cpha ^ cpol))
        rx_sr = {rx_sr[6:0], i_dut.mosi};
      // stale miso never looks valid
      o_line.miso = ~o_line.miso;
    end
  end
  // master side, msb first, 80 ns bit
  task xfer(input logic [7:0] tx);
    integer i;
    o_line.sck = cpol;
    o_line.select_input_n = 1'b0;
    #80;
    for (i = 7; i >= 0; i--)
    begin
      if (!cpha)
        o_line.mosi = tx[i];
      #40;
      o_line.sck = !cpol;
      if (!cpha)
        rx_sr = {rx_sr[6:0], i_dut.miso};
      else
        o_line.mosi = tx[i];
      #40;
      o_line.sck = cpol;
      if (cpha)
        rx_sr = {rx_sr[6:0], i_dut.miso};
    end
    #80;
    o_line.select_input_n = 1'b1;
    o_line.mosi = ~o_line.mosi;
  endtask
endmodule

/* File: verif/tb.sv */
// self-checking bench for the spi configuration and status register
// assumes the peer model on the pins and the checker bound in
`timescale 1ns/100ps
`include "spi_cfg_params.svh"
module tb
  import spi_cfg_pkg::*;
;
  logic i_core_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic i_unit_enable = 1'b0;
  logic i_tx_write = 1'b0;
  logic i_rx_read = 1'b0;
  logic [7:0] i_sfr_addr = `SPI_CFG_ADDR;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic [7:0] i_tx_data = 8'h00;
  logic [7:0] o_sfr_rdata;
  logic [7:0] o_rx_data;
  logic o_tx_buf_empty;
  logic o_xfer_done;
  spi_pins_in_t i_pins;
  spi_pins_out_t o_pins;
  logic [7:0] d;
  logic [7:0] k;
  logic sb;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int c;

  always #4 i_core_clk = ~i_core_clk;

  spi_config_status_register DUT (.*);
  spi_peer_model peer (.i_dut(o_pins), .o_line(i_pins));

  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_core_clk);
    i_sfr_addr = a;
    i_sfr_wdata = v;
    i_sfr_wr = 1'b1;
    @(negedge i_core_clk);
    i_sfr_wr = 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(negedge i_core_clk);
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    @(negedge i_core_clk);
    d = o_sfr_rdata;
    i_sfr_rd = 1'b0;
  endtask

  task send_tx(input logic [7:0] v);
    @(negedge i_core_clk);
    i_tx_data = v;
    i_tx_write = 1'b1;
    @(negedge i_core_clk);
    i_tx_write = 1'b0;
  endtask

  task set_mode(input logic [2:0] cf);
    i_unit_enable = 1'b0;
    wr(`SPI_CFG_ADDR, {1'b0, cf, 4'h0});
    peer.cpha = cf[1];
    peer.cpol = cf[0];
    peer.o_line.sck = cf[0];
    repeat (4) @(negedge i_core_clk);
    i_unit_enable = 1'b1;
  endtask

  // ceiling well above the thousand or so cycles the tests need
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      tally_and_finish;
    end
  end

  initial
  begin
    repeat (12) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_arst_n = 1'b1;
    repeat (8) @(negedge i_core_clk);
    rd(`SPI_CFG_ADDR);
    chk(d, 8'h07);
    wr(8'hA0, 8'hFF);
    rd(8'hA0);
    chk(d, 8'h00);
    rd(`SPI_CFG_ADDR);
    chk(d, 8'h07);
    $display("test reset done");
    for (k = 0; k < 8; k++)
    begin
      wr(`SPI_CFG_ADDR, {1'b1, k[2:0], 4'hF});
      rd(`SPI_CFG_ADDR);
      chk(d, {1'b0, k[2:0], 4'h7});
    end
    $display("test config done");
    for (k = 0; k < 4; k++)
    begin
      set_mode({1'b0, k[1:0]});
      send_tx(8'hA5 ^ k);
      chk({7'h00, o_tx_buf_empty}, 8'h00);
      rd(`SPI_CFG_ADDR);
      chk(d, {2'b00, k[1:0], 4'h5});
      chk({7'h00, o_tx_buf_empty}, 8'h01);
      fork
        peer.xfer(8'h3C + k);
        begin
          #300;
          rd(`SPI_CFG_ADDR);
          chk(d, {2'b10, k[1:0], 4'h9});
        end
      join
      repeat (10) @(negedge i_core_clk);
      rd(`SPI_CFG_ADDR);
      chk(d, {2'b00, k[1:0], 4'h6});
      chk(o_rx_data, 8'h3C + k);
      chk(peer.rx_sr, 8'hA5 ^ k);
      @(negedge i_core_clk);
      i_rx_read = 1'b1;
      @(negedge i_core_clk);
      i_rx_read = 1'b0;
      rd(`SPI_CFG_ADDR);
      chk(d, {2'b00, k[1:0], 4'h7});
    end
    $display("test slave done");
    @(negedge i_core_clk);
    peer.o_line.select_input_n = 1'b0;
    @(negedge i_core_clk);
    peer.o_line.select_input_n = 1'b1;
    rd(`SPI_CFG_ADDR);
    chk(d & 8'h08, 8'h00);
    rd(`SPI_CFG_ADDR);
    chk(d & 8'h08, 8'h00);
    $display("test glitch done");
    for (k = 0; k < 4; k++)
    begin
      set_mode({1'b1, k[1:0]});
      send_tx(8'hC3 ^ k);
      sb = 1'b0;
      c = 0;
      i_sfr_rd = 1'b1;
      do
      begin
        @(negedge i_core_clk);
        sb = sb | o_sfr_rdata[7];
        c++;
      end while (!o_xfer_done && c < 200);
      i_sfr_rd = 1'b0;
      chk({7'h00, sb}, 8'h01);
      repeat (16) @(negedge i_core_clk);
      chk(peer.rx_sr, 8'hC3 ^ k);
      chk({7'h00, o_pins.sck}, {7'h00, k[0]});
      rd(`SPI_CFG_ADDR);
      chk(d, {2'b01, k[1:0], 4'h7});
    end
    $display("test master done");
    tally_and_finish;
  end
endmodule
